// >>> rtl/rtc_link_slave.sv
// Two-wire slave port of the clock device: control/status and user SRAM.
// Assumes bus lines from the interface, sampled on clk_sys.
`timescale 1ns/1ps
`include "rtc_link_regs.svh"

// Overview of operation
// - Master sends identifier after START
// - Decode control and SRAM identifiers
// - Low address bit selects direction
// - Compare after full byte, then acknowledge
// - Word address byte follows identifier
// - Address counter resets to zero
// - Random read repeats same identifier
// - Single write acknowledged thrice, then standby
// - Page write acknowledges each byte
// - Address never wraps within page
// - Read preamble bytes all acknowledged
// - Send bytes while master acknowledges
// - Pointer loads then advances per byte
// - Master stops after section end; this master reads on for cmd_len bytes, and bytes past the end read as zero
// - Bytes travel most significant first
// - Master acknowledges wanted read bytes except the last
// - SRAM holds 128 bytes
module rtc_link_slave
    import rtc_link_pkg::*;
#(
    parameter int SRAM_BYTES = `SRAM_DEPTH,
    parameter int CTRL_BYTES = `CTRL_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    rtc_link_if.slave link,
    output logic [7:0] user_wr_addr, // Last written location
    output logic [7:0] user_wr_data, // Last written byte
    output logic user_wr_ctrl, // Last write hit control section
    output logic user_wr_strobe, // One-cycle pulse per write
    output logic [7:0] user_ptr // Current address counter
);
    // ----------------------------------------------
    // Synchronisers and edge detection
    // ----------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q; // Two-stage catchers
    logic scl_q, sda_q; // Previous synced values
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], link.scl};
            sda_sync_q <= {sda_sync_q[0], link.sda};
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end
    wire scl_s = scl_sync_q[1]; // Synced clock
    wire sda_s = sda_sync_q[1]; // Synced data
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;

    // ----------------------------------------------
    // Storage: SRAM and control/status section
    // ----------------------------------------------
    logic [7:0] sram_q [SRAM_BYTES];
    logic [7:0] ctrl_q [CTRL_BYTES];

    // ----------------------------------------------
    // Protocol state
    // ----------------------------------------------
    slave_state_e state_q, state_d;
    logic [7:0] ptr_q; // Shared address counter
    logic ctrl_sel_q; // Region: 1 = control/status
    logic sda_drive_q; // Pull data line low
    logic [7:0] txbit_q; // Byte being sent
    logic wr_strobe_q;
    logic [7:0] wr_addr_q, wr_data_q;
    logic wr_ctrl_q;

    logic [7:0] rx_data;
    logic [3:0] rx_count;
    wire byte_done = (rx_count == 4'h8);

    // Identifier decoding, used for match and region choice
    function automatic logic [1:0] id_decode(input logic [6:0] id);
        id_decode = {id == `ID_CONTROL_STATUS, id == `ID_USER_SRAM};
    endfunction
    wire [1:0] id_hit = id_decode(rx_data[7:1]);
    wire id_match = |id_hit;
    wire rd_dir = rx_data[0];

    // Byte at the pointer, zero beyond the section end
    wire [7:0] rd_byte = ctrl_sel_q ?
        ((32'(ptr_q) < CTRL_BYTES) ? ctrl_q[ptr_q[5:0]] : 8'h00) :
        ((32'(ptr_q) < SRAM_BYTES) ? sram_q[ptr_q[6:0]] : 8'h00);

    // Shift only in receive phases, never on an acknowledge clock
    wire rx_phase = (state_q == SL_ADDR) || (state_q == SL_WORD) ||
        (state_q == SL_WDATA);

    byte_shifter u_rx (
        .clk_sys(clk_sys),
        .reset(reset),
        .clear(start_cond || (scl_fall && byte_done)),
        .load(1'b0),
        .load_byte(8'h00),
        .shift(scl_rise && rx_phase && rx_count != 4'h8),
        .bit_in(sda_s),
        .data(rx_data),
        .count(rx_count)
    );

    // ----------------------------------------------
    // Next-state decode
    // ----------------------------------------------
    always_comb begin
        state_d = state_q;
        if (start_cond) begin
            state_d = SL_ADDR;
        end else if (stop_cond) begin
            state_d = SL_IDLE;
        end else if (scl_fall) begin
            unique case (state_q)
                SL_IDLE: state_d = SL_IDLE;
                SL_ADDR: begin
                    // Compare only once the whole byte is in
                    if (byte_done) begin
                        state_d = id_match ? SL_ADDR_ACK : SL_IDLE;
                    end
                end
                SL_ADDR_ACK: state_d = rd_dir ? SL_RDATA : SL_WORD;
                SL_WORD: if (byte_done) state_d = SL_WORD_ACK;
                SL_WORD_ACK: state_d = SL_WDATA;
                SL_WDATA: if (byte_done) state_d = SL_WDATA_ACK;
                SL_WDATA_ACK: state_d = SL_WDATA;
                // Ninth bit: master acknowledge keeps sending
                SL_RDATA: if (rx_count == 4'h9) begin
                    state_d = SL_RDATA;
                end
            endcase
        end
    end

    // ----------------------------------------------
    // Sequencing, pointer, data line
    // ----------------------------------------------
    logic [3:0] tx_idx_q; // Bits sent in this read byte
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= SL_IDLE;
            ptr_q <= `ADDR_RESET;
            ctrl_sel_q <= 1'b0;
            sda_drive_q <= 1'b0;
            txbit_q <= 8'h00;
            tx_idx_q <= 4'h0;
            wr_strobe_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_ctrl_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wr_strobe_q <= 1'b0;
            if (start_cond || stop_cond) begin
                sda_drive_q <= 1'b0;
                tx_idx_q <= 4'h0;
            end else if (scl_fall) begin
                unique case (state_q)
                    SL_ADDR: if (byte_done && id_match) begin
                        sda_drive_q <= 1'b1;
                        ctrl_sel_q <= id_hit[1];
                    end
                    SL_ADDR_ACK: begin
                        sda_drive_q <= 1'b0;
                        if (rd_dir) begin
                            // First read bit leaves at once
                            txbit_q <= rd_byte;
                            sda_drive_q <= ~rd_byte[7];
                            tx_idx_q <= 4'h1;
                        end
                    end
                    SL_WORD: if (byte_done) begin
                        ptr_q <= rx_data;
                        sda_drive_q <= 1'b1;
                    end
                    SL_WDATA: if (byte_done) begin
                        sda_drive_q <= 1'b1;
                        wr_strobe_q <= 1'b1;
                        wr_addr_q <= ptr_q;
                        wr_data_q <= rx_data;
                        wr_ctrl_q <= ctrl_sel_q;
                        ptr_q <= ptr_q + 8'h01;
                    end
                    SL_WORD_ACK, SL_WDATA_ACK: sda_drive_q <= 1'b0;
                    SL_RDATA: begin
                        if (tx_idx_q < 4'h8) begin
                            sda_drive_q <= ~txbit_q[3'(4'h7 - tx_idx_q)];
                            tx_idx_q <= tx_idx_q + 4'h1;
                        end else if (tx_idx_q == 4'h8) begin
                            // Release for the master acknowledge
                            sda_drive_q <= 1'b0;
                            ptr_q <= ptr_q + 8'h01;
                            tx_idx_q <= 4'h9;
                        end
                    end
                    default: sda_drive_q <= 1'b0;
                endcase
            end else if (scl_rise && state_q == SL_RDATA &&
                         tx_idx_q == 4'h9) begin
                // Sample master acknowledge on the ninth clock
                if (sda_s) begin
                    state_q <= SL_IDLE;
                    tx_idx_q <= 4'h0;
                end else begin
                    txbit_q <= rd_byte;
                    tx_idx_q <= 4'hA;
                end
            end else if (state_q == SL_RDATA && tx_idx_q == 4'hA &&
                         ~scl_s) begin
                sda_drive_q <= ~txbit_q[7];
                tx_idx_q <= 4'h1;
            end
        end
    end

    // ----------------------------------------------
    // Memory writes
    // ----------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < SRAM_BYTES; i++) sram_q[i] <= 8'h00;
            for (int i = 0; i < CTRL_BYTES; i++) ctrl_q[i] <= 8'h00;
        end else if (wr_strobe_q) begin
            if (wr_ctrl_q && 32'(wr_addr_q) < CTRL_BYTES) begin
                ctrl_q[wr_addr_q[5:0]] <= wr_data_q;
            end else if (!wr_ctrl_q && 32'(wr_addr_q) < SRAM_BYTES) begin
                sram_q[wr_addr_q[6:0]] <= wr_data_q;
            end
        end
    end

    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe = sda_drive_q;
    assign user_wr_addr = wr_addr_q;
    assign user_wr_data = wr_data_q;
    assign user_wr_ctrl = wr_ctrl_q;
    assign user_wr_strobe = wr_strobe_q;
    assign user_ptr = ptr_q;
endmodule

// >>> rtl/rtc_link_regs.svh
// Constants of the two-wire slave port: identifiers, sizes, timing.
// Assumes inclusion by bare name from packages and modules alike.
`ifndef RTC_LINK_REGS_SVH
`define RTC_LINK_REGS_SVH

// Seven-bit identifiers of the two regions
`define ID_CONTROL_STATUS 7'h6F
`define ID_USER_SRAM 7'h57
// Reset value of the shared address counter
`define ADDR_RESET 8'h00
// Region sizes in bytes
`define SRAM_DEPTH 128
`define CTRL_DEPTH 48
// Master bit clock: half period in system clocks
`define SCL_HALF_CYCLES 16'h0028

`endif

// >>> rtl/rtc_link_pkg.sv
// Types shared by both ends of the two-wire link.
// Assumes the constants header sits beside it in rtl/.
`include "rtc_link_regs.svh"

package rtc_link_pkg;

    // Slave protocol states
    typedef enum logic [2:0] {
        SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_WORD, SL_WORD_ACK,
        SL_WDATA, SL_WDATA_ACK, SL_RDATA
    } slave_state_e;

    // Master sequencer states
    typedef enum logic [3:0] {
        MS_IDLE, MS_START, MS_BIT_LO, MS_BIT_HI, MS_ACK_LO,
        MS_ACK_HI, MS_STOP_LO, MS_STOP_HI, MS_RESTART_LO,
        MS_RESTART_HI
    } master_state_e;

    // Byte-level command to the master end
    typedef enum logic [1:0] {
        CMD_WRITE, CMD_READ_RANDOM, CMD_READ_CURRENT
    } master_cmd_e;

endpackage

// >>> rtl/rtc_link_if.sv
// Interface joining the bus master and the slave port.
// Assumes open-drain wires with pull-ups resolved here.
`timescale 1ns/1ps

interface rtc_link_if;
    logic scl_o; // Master clock drive value
    logic scl_oe; // Master clock enable, pulls low
    logic sda_m_o; // Master data drive value
    logic sda_m_oe; // Master data enable
    logic sda_s_o; // Slave data drive value
    logic sda_s_oe; // Slave data enable
    logic scl; // Resolved clock line
    logic sda; // Resolved data line

    // Open-drain resolution with pull-ups
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe,
                    input scl, sda);
    modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// >>> rtl/byte_shifter.sv
// Eight-bit shift register with bit counter, used by the slave.
// Assumes the caller presents one shift strobe per bus bit.
`timescale 1ns/1ps

module byte_shifter (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clear, // Restart bit count
    input wire logic load, // Load parallel byte
    input wire logic [7:0] load_byte,
    input wire logic shift, // Shift in one bit
    input wire logic bit_in,
    output logic [7:0] data, // Shift register contents
    output logic [3:0] count // Bits shifted since clear
);
    logic [7:0] data_q;
    logic [3:0] count_q;

    // ----------------------------------------------
    // Shift, most significant bit first
    // ----------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            data_q <= 8'h00;
            count_q <= 4'h0;
        end else if (load) begin
            data_q <= load_byte;
            count_q <= 4'h0;
        end else if (clear) begin
            count_q <= 4'h0;
        end else if (shift) begin
            data_q <= {data_q[6:0], bit_in};
            count_q <= count_q + 4'h1;
        end
    end

    assign data = data_q;
    assign count = count_q;
endmodule

// >>> rtl/rtc_link_master.sv
// Two-wire bus master issuing writes and reads to the slave port.
// Assumes one command at a time, held while busy is high.
`timescale 1ns/1ps
`include "rtc_link_regs.svh"

module rtc_link_master
    import rtc_link_pkg::*;
#(
    parameter logic [15:0] HALF = `SCL_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    rtc_link_if.master link,
    input wire logic cmd_valid, // Start a transfer
    output logic cmd_ready, // Idle, command taken
    input wire master_cmd_e cmd_kind,
    input wire logic [6:0] cmd_id, // Target identifier
    input wire logic [7:0] cmd_addr, // Word address
    input wire logic [7:0] cmd_len, // Byte count, at least one
    input wire logic [7:0] wr_byte, // Next byte to write
    output logic wr_take, // Pulse: wr_byte consumed
    output logic [7:0] rd_byte, // Last byte read
    output logic rd_valid, // Pulse: rd_byte fresh
    output logic nack_seen // Slave failed to acknowledge
);
    master_state_e state_q;
    logic [15:0] tmr_q; // Half-period timer
    logic [7:0] sh_q; // Outgoing or incoming byte
    logic [2:0] bit_q; // Bit index
    logic [1:0] phase_q; // 0 id, 1 addr, 2 data, 3 read id
    logic rd_phase_q; // Receiving data
    logic [7:0] left_q; // Data bytes left
    logic scl_low_q, sda_low_q, nack_q, rdv_q, take_q;
    logic [7:0] rd_q;
    master_cmd_e kind_q;
    logic [6:0] id_q;
    logic [7:0] addr_q;
    logic [1:0] sda_sync_q; // Data line catcher

    wire tick = (tmr_q == 16'h0000);
    wire sda_s = sda_sync_q[1];
    wire last = (left_q == 8'h01);

    // ----------------------------------------------
    // Bit clock divider and sequencer
    // ----------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= MS_IDLE;
            tmr_q <= 16'h0000;
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            phase_q <= 2'h0;
            rd_phase_q <= 1'b0;
            left_q <= 8'h00;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            nack_q <= 1'b0;
            rdv_q <= 1'b0;
            take_q <= 1'b0;
            rd_q <= 8'h00;
            kind_q <= CMD_WRITE;
            id_q <= 7'h00;
            addr_q <= 8'h00;
            sda_sync_q <= 2'b11;
        end else begin
            sda_sync_q <= {sda_sync_q[0], link.sda};
            rdv_q <= 1'b0;
            take_q <= 1'b0;
            tmr_q <= tick ? HALF : tmr_q - 16'h0001;
            if (state_q == MS_IDLE) begin
                tmr_q <= HALF;
                if (cmd_valid) begin
                    kind_q <= cmd_kind;
                    id_q <= cmd_id;
                    addr_q <= cmd_addr;
                    left_q <= cmd_len;
                    nack_q <= 1'b0;
                    rd_phase_q <= 1'b0;
                    // Identifier first; direction bit by command
                    sh_q <= {cmd_id, cmd_kind == CMD_READ_CURRENT};
                    phase_q <= (cmd_kind == CMD_READ_CURRENT) ? 2'h3 : 2'h0;
                    sda_low_q <= 1'b1;
                    state_q <= MS_START;
                end
            end else if (tick) begin
                unique case (state_q)
                    // Repeated START: data falls while clock is high
                    MS_RESTART_HI: begin
                        sda_low_q <= 1'b1;
                        state_q <= MS_START;
                    end
                    MS_START: begin
                        sda_low_q <= 1'b1;
                        scl_low_q <= 1'b1;
                        bit_q <= 3'h7;
                        state_q <= MS_BIT_LO;
                    end
                    MS_BIT_LO: begin
                        sda_low_q <= rd_phase_q ? 1'b0 : ~sh_q[bit_q];
                        scl_low_q <= 1'b0;
                        state_q <= MS_BIT_HI;
                    end
                    MS_BIT_HI: begin
                        if (rd_phase_q) sh_q[bit_q] <= sda_s;
                        scl_low_q <= 1'b1;
                        bit_q <= bit_q - 3'h1;
                        state_q <= (bit_q == 3'h0) ? MS_ACK_LO : MS_BIT_LO;
                    end
                    MS_ACK_LO: begin
                        // Acknowledge read data unless last wanted
                        sda_low_q <= rd_phase_q & ~last;
                        scl_low_q <= 1'b0;
                        state_q <= MS_ACK_HI;
                    end
                    MS_ACK_HI: begin
                        scl_low_q <= 1'b1;
                        bit_q <= 3'h7;
                        state_q <= MS_BIT_LO;
                        if (rd_phase_q) begin
                            rd_q <= sh_q;
                            rdv_q <= 1'b1;
                            left_q <= left_q - 8'h01;
                            if (last) state_q <= MS_STOP_LO;
                        end else if (sda_s) begin
                            nack_q <= 1'b1;
                            state_q <= MS_STOP_LO;
                        end else if (phase_q == 2'h0) begin
                            sh_q <= addr_q;
                            phase_q <= 2'h1;
                        end else if (phase_q == 2'h1 &&
                                     kind_q == CMD_READ_RANDOM) begin
                            state_q <= MS_RESTART_LO;
                        end else if (phase_q == 2'h3) begin
                            rd_phase_q <= 1'b1;
                        end else if (phase_q == 2'h2 && last) begin
                            state_q <= MS_STOP_LO;
                        end else begin
                            if (phase_q == 2'h2) left_q <= left_q - 8'h01;
                            sh_q <= wr_byte;
                            take_q <= 1'b1;
                            phase_q <= 2'h2;
                        end
                    end
                    MS_STOP_LO: begin
                        sda_low_q <= 1'b1;
                        scl_low_q <= 1'b0;
                        state_q <= MS_STOP_HI;
                    end
                    MS_STOP_HI: begin
                        sda_low_q <= 1'b0;
                        state_q <= MS_IDLE;
                    end
                    MS_RESTART_LO: begin
                        sda_low_q <= 1'b0;
                        scl_low_q <= 1'b0;
                        // Same identifier, now reading
                        sh_q <= {id_q, 1'b1};
                        phase_q <= 2'h3;
                        state_q <= MS_RESTART_HI;
                    end
                    default: state_q <= MS_IDLE;
                endcase
            end
        end
    end

    assign link.scl_o = 1'b0;
    assign link.scl_oe = scl_low_q;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe = sda_low_q;
    assign cmd_ready = (state_q == MS_IDLE);
    assign wr_take = take_q;
    assign rd_byte = rd_q;
    assign rd_valid = rdv_q;
    assign nack_seen = nack_q;
endmodule

// >>> verification/rtc_link_chk.sv
// Checker of the two-wire lines between master and slave port.
// Assumes the bench passes the interface signals by name.
`timescale 1ns/1ps
`include "rtc_link_regs.svh"
module rtc_link_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    // ------------
    // Wire tracking
    // ------------
    localparam int LOW_MAX = 120; // Longest clock low time
    logic scl_q, sda_q, rd_q, first_q;
    logic [3:0] bit_q; // Clock rises since START or the last ninth clock
    logic [7:0] sh_q, low_q; // Byte on wire, low time
    wire s_low = sda_s_oe & ~sda_s_o; // Slave pulls low
    wire rise = scl & ~scl_q;
    wire start = scl & scl_q & sda_q & ~sda;
    wire stop = scl & scl_q & ~sda_q & sda;
    wire ack = rise & (bit_q == 4'h8); // Ninth clock
    wire id_ok = (sh_q[7:1] == `ID_CONTROL_STATUS) |
        (sh_q[7:1] == `ID_USER_SRAM);
    // Bit count, first byte and read phase
    always_ff @(posedge clk_sys) begin
        scl_q <= scl;
        sda_q <= sda;
        low_q <= scl ? 8'h00 : low_q + 8'h01;
        if (rise && !ack) begin
            sh_q <= {sh_q[6:0], sda};
        end
        if (reset) begin
            bit_q <= 4'h0;
            first_q <= 1'b0;
            rd_q <= 1'b0;
        end else if (start) begin
            bit_q <= 4'h0;
            first_q <= 1'b1;
            rd_q <= 1'b0;
        end else if (rise) begin
            bit_q <= ack ? 4'h0 : bit_q + 4'h1;
            first_q <= first_q & !ack;
            rd_q <= rd_q | (ack & first_q & sh_q[0]);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_id_decode: assert property
        (ack && first_q |-> s_low == id_ok) else $error("id answer");
    chk_write_ack: assert property
        (ack && !first_q && !rd_q |-> s_low) else $error("no ack");
    chk_ack_slot: assert property
        (rise && s_low && !rd_q |-> bit_q == 4'h8) else $error("early ack");
    chk_read_slot: assert property
        (ack && rd_q |-> !s_low) else $error("ack slot held");
    chk_slave_steady: assert property
        (scl && scl_q |-> $stable(s_low)) else $error("data moved");
    chk_start_free: assert property
        (start |-> !s_low) else $error("held at start");
    chk_stop_quiet: assert property
        (stop |=> !s_low [*8]) else $error("held after stop");
    chk_scl_low: assert property
        (low_q < LOW_MAX) else $error("clock stuck low");
    cover property (ack && rd_q);
    cover property (ack && first_q && !id_ok);
    cover property (stop);
endmodule

// >>> verification/i2c_rtc_sram_slave_port_tb_top.sv
// Bench: master and slave port face each other over the link.
// Assumes the rtl/ files and the checker are compiled first.
`timescale 1ns/1ps
`include "rtc_link_regs.svh"
module i2c_rtc_sram_slave_port_tb_top
    import rtc_link_pkg::*;
;
    // ------------
    // Signals and models
    // ------------
    logic clk_sys, reset, cmd_valid, cmd_ready, wr_take, rd_valid;
    logic nack_seen, user_wr_ctrl, user_wr_strobe;
    master_cmd_e cmd_kind;
    logic [6:0] cmd_id, id;
    logic [7:0] cmd_addr, cmd_len, wr_byte, rd_byte, user_wr_addr;
    logic [7:0] user_wr_data, user_ptr, seed, ptr_m, a, n;
    logic [7:0] sram [`SRAM_DEPTH]; // Memory models
    logic [7:0] ctl [`CTRL_DEPTH];
    logic [16:0] wq [$]; // Expected writes: section, address, data
    logic [7:0] rq [$], dq [$]; // Expected reads, bytes to send
    int err_count, check_count, cyc, tn;
    wire [16:0] wr_seen = {user_wr_ctrl, user_wr_addr, user_wr_data};
    rtc_link_if lnk ();
    rtc_link_master #(.HALF(16'h0008)) i_rtc_link_master (.clk_sys,
        .reset, .link(lnk), .cmd_valid, .cmd_ready, .cmd_kind, .cmd_id,
        .cmd_addr, .cmd_len, .wr_byte, .wr_take, .rd_byte, .rd_valid,
        .nack_seen);
    rtc_link_slave i_rtc_link_slave (.clk_sys, .reset, .link(lnk),
        .user_wr_addr, .user_wr_data, .user_wr_ctrl, .user_wr_strobe,
        .user_ptr);
    rtc_link_chk i_rtc_link_chk (.clk_sys, .reset, .sda_s_o(lnk.sda_s_o),
        .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl), .sda(lnk.sda));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Reads past a section end give zero
    function automatic logic [7:0] mem_rd(input logic c, input int x);
        if (c) begin
            return (x < `CTRL_DEPTH) ? ctl[x] : 8'h00;
        end
        return (x < `SRAM_DEPTH) ? sram[x] : 8'h00;
    endfunction
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One command; expectations built first
    task automatic xfer(input master_cmd_e k, input logic [6:0] t,
                        input logic [7:0] s, input logic [7:0] m);
        logic c, bad;
        int p;
        c = t == `ID_CONTROL_STATUS;
        bad = !c && t != `ID_USER_SRAM;
        p = (k == CMD_READ_CURRENT) ? ptr_m : s;
        dq.delete();
        for (int i = 0; i < m && !bad; i++) begin
            if (k != CMD_WRITE) begin
                rq.push_back(mem_rd(c, p + i));
            end else begin
                seed = lfsr(seed);
                dq.push_back(seed);
                wq.push_back({c, 8'(p + i), seed});
                if (c) begin
                    ctl[p + i] = seed;
                end else begin
                    sram[p + i] = seed;
                end
            end
        end
        if (!bad) begin
            ptr_m = 8'(p + m);
        end
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1) @(negedge clk_sys);
        cmd_kind = k;
        cmd_id = t;
        cmd_addr = s;
        cmd_len = m;
        if (dq.size() > 0) begin
            wr_byte = dq[0];
        end
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1) @(negedge clk_sys);
        chk(17'(nack_seen), 17'(bad));
        chk(17'(user_ptr), 17'(ptr_m));
        chk(17'(wq.size() + rq.size()), 17'h00000);
        tn++;
        $display("test %0d done", tn);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            test_done();
        end
    end
    // Byte feeder and output monitors
    always @(negedge clk_sys) begin
        if (wr_take === 1'b1) begin
            void'(dq.pop_front());
            if (dq.size() > 0) begin
                wr_byte <= dq[0];
            end
        end
        if (user_wr_strobe === 1'b1) begin
            chk(wr_seen, wq.pop_front());
        end
        if (rd_valid === 1'b1) begin
            chk({9'h000, rd_byte}, {9'h000, rq.pop_front()});
        end
    end
    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_kind = CMD_WRITE;
        cmd_id = 7'h00;
        cmd_addr = 8'h00;
        cmd_len = 8'h01;
        wr_byte = 8'h00;
        seed = 8'h4A;
        ptr_m = `ADDR_RESET;
        sram = '{default: 8'h00};
        ctl = '{default: 8'h00};
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        xfer(CMD_READ_CURRENT, `ID_USER_SRAM, 8'h00, 8'h02);
        xfer(CMD_WRITE, `ID_USER_SRAM, 8'h7C, 8'h04);
        xfer(CMD_READ_RANDOM, `ID_USER_SRAM, 8'h7E, 8'h03);
        xfer(CMD_WRITE, 7'h50, 8'h00, 8'h01);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            id = i[0] ? `ID_CONTROL_STATUS : `ID_USER_SRAM;
            a = i[0] ? 8'(seed % 8'd44) : seed & 8'h7B;
            n = {6'h00, seed[3:2]} + 8'h01;
            xfer(CMD_WRITE, id, a, n);
            xfer(CMD_READ_RANDOM, id, a, n);
            xfer(CMD_READ_CURRENT, id, 8'h00, 8'h01);
        end
        test_done();
    end
endmodule
